// file: rtl/ptpb_consts.vh
// field positions, subspan count and limits for the pixel thread payload
// builder; included by the builder module only
`ifndef PTPB_CONSTS_VH
`define PTPB_CONSTS_VH

// header dword 3
`define PTPB_SCR_HI 3
`define PTPB_SCR_LO 0
`define PTPB_SCR_MAX 4'hb
`define PTPB_SCR_EXC_CODE 4'hb
`define PTPB_SCRRSV_HI 31
`define PTPB_SCRRSV_LO 4
// header dword 1
`define PTPB_CCPTR_HI 31
`define PTPB_CCPTR_LO 6
`define PTPB_CCRSV_HI 5
`define PTPB_CCRSV_LO 0
// header dword 0
`define PTPB_MASK_HI 31
`define PTPB_MASK_LO 16
`define PTPB_COPY_HI 15
`define PTPB_COPY_LO 0
// coordinate dword 7
`define PTPB_VP_HI 30
`define PTPB_VP_LO 27
`define PTPB_RTA_HI 26
`define PTPB_RTA_LO 16
`define PTPB_VPRSV_BIT 31
`define PTPB_D7RSV_HI 15
`define PTPB_D7RSV_LO 0
// coordinate dword 6
`define PTPB_FACE_BIT 31
`define PTPB_SDP_BIT 30
`define PTPB_SDRT_BIT 29
`define PTPB_DDP_BIT 28
`define PTPB_DSP_BIT 27
`define PTPB_AART_BIT 26
`define PTPB_AAP_BIT 25
`define PTPB_TOPO_HI 4
`define PTPB_TOPO_LO 0
`define PTPB_D6RSV_HI 24
`define PTPB_D6RSV_LO 5
// coordinate dwords 2..5 hold subspans 0..3
`define PTPB_SSP_DW0 2
// alpha/stencil register dwords
`define PTPB_AA_DW_LO 6
`define PTPB_AA_DW_HI 7
// subspan count and fill constants
`define PTPB_NSUB 4
`define PTPB_ZERO32 32'h00000000
`define PTPB_ONES4 4'hf
`define PTPB_ZERO4 4'h0

`endif

// file: rtl/ptpb_builder.v
// payload builder: turns one dispatch request into a stream of 256-bit
// payload registers (header, coordinates, optional depth and alpha/stencil)
// assumes the windower holds the request fields steady while req_busy is
// high, and the shader side takes one register per cycle when ready
`timescale 1ns/1ps
`default_nettype none
`include "ptpb_consts.vh"

module ptpb_builder (
  input wire sys_clk,
  input wire reset,
  // dispatch request from the windower
  input wire req_valid,
  output wire req_ready,
  input wire [3:0] scratch_code,
  input wire early_stepping,
  input wire scratch_exc_enable,
  input wire [25:0] colour_calc_state_block,
  input wire [15:0] lit_mask,
  input wire [3:0] viewport_index,
  input wire [10:0] rt_array_index,
  input wire back_facing,
  input wire src_depth_present,
  input wire src_depth_to_rt,
  input wire dst_depth_present,
  input wire dst_stencil_present,
  input wire aa_alpha_to_rt,
  input wire aa_alpha_present,
  input wire [4:0] topology_type,
  // subspan g at [32g+31:32g]: vertical high half, horizontal low half
  input wire [127:0] subspan_pos,
  input wire [31:0] start_vertical,
  input wire [31:0] start_horizontal,
  input wire [511:0] src_depth,
  input wire [63:0] aa_alpha,
  input wire [127:0] dst_stencil,
  // payload stream toward the shader thread
  output reg out_valid,
  input wire out_ready,
  output reg [255:0] out_data,
  output reg out_last,
  output reg [15:0] dispatch_mask,
  output reg [19:0] scratch_bytes_kb,
  output wire req_busy
);

  // one-hot phase states
  localparam ST_IDLE = 6'b000001;
  localparam ST_HDR = 6'b000010;
  localparam ST_CRD = 6'b000100;
  localparam ST_DZ0 = 6'b001000;
  localparam ST_DZ1 = 6'b010000;
  localparam ST_AS = 6'b100000;

  reg [5:0] state_reg;
  reg [5:0] state_next;
  wire alpha_eff;
  wire as_needed;
  wire [255:0] hdr_word;
  wire [255:0] crd_word;
  wire [255:0] dz0_word;
  wire [255:0] dz1_word;
  wire [255:0] as_word;
  wire [15:0] dmask_w;
  wire [19:0] scr_kb_w;
  // header dwords 0..3, the rest of the header is zero
  wire [31:0] hdr_dw0;
  wire [31:0] hdr_dw1;
  wire [31:0] hdr_dw2;
  wire [31:0] hdr_dw3;
  // coordinate dwords carrying the flag and index fields
  wire [31:0] crd_dw6;
  wire [31:0] crd_dw7;
  wire adv;
  reg [255:0] word_sel;
  reg last_sel;

  // ------------------------------------------------------------------
  // payload map
  // ------------------------------------------------------------------
  // beat 0, header:
  //   dword 0  lit mask high half, editable copy low half
  //   dword 1  colour calc state pointer, 64-byte aligned
  //   dword 2  zero, kept free for message header fields
  //   dword 3  scratch size code in the low nibble
  //   dwords 4..7  owned by other fixed functions, zero here
  // beat 1, coordinates:
  //   dwords 0,1  float start vertex, horizontal then vertical
  //   dwords 2..5  subspan upper-left positions, subspan 0 first
  //   dword 6  facing, presence flags, topology type
  //   dword 7  viewport index and render target array index
  // beats 2,3, only with source depth:
  //   interpolated depth, subspans 0,1 then subspans 2,3
  // last beat, only with alpha or stencil:
  //   dwords 0..3 stencil, 4,5 zero, 6,7 alpha coverage
  // destination depth is flagged but never carried; a kernel that
  // relies on it would read the following data instead
  // 32-pixel extension beats are not produced by this block

  // ------------------------------------------------------------------
  // header register
  // ------------------------------------------------------------------
  // both halves leave identical; only the shader edits the copy
  assign hdr_dw0[`PTPB_MASK_HI:`PTPB_MASK_LO] = lit_mask;
  assign hdr_dw0[`PTPB_COPY_HI:`PTPB_COPY_LO] = lit_mask;
  // aligned pointer, so the low six bits carry nothing
  assign hdr_dw1[`PTPB_CCPTR_HI:`PTPB_CCPTR_LO] =
    colour_calc_state_block;
  assign hdr_dw1[`PTPB_CCRSV_HI:`PTPB_CCRSV_LO] = 6'h00;
  // held back for message header fields
  assign hdr_dw2 = `PTPB_ZERO32;
  // size code goes out verbatim, even codes above the range
  assign hdr_dw3[`PTPB_SCRRSV_HI:`PTPB_SCRRSV_LO] = 28'h0000000;
  assign hdr_dw3[`PTPB_SCR_HI:`PTPB_SCR_LO] = scratch_code;
  // dwords 7..4 belong to other fixed functions; zero here
  assign hdr_word[255:128] = {4{`PTPB_ZERO32}};
  assign hdr_word[127:0] = {hdr_dw3, hdr_dw2, hdr_dw1, hdr_dw0};

  // informational decode of the scratch size; not used by the stream
  assign scr_kb_w = (scratch_code > `PTPB_SCR_MAX) ? 20'h00000 :
    !early_stepping ? (20'h00001 << scratch_code) :
    (scratch_exc_enable && scratch_code == `PTPB_SCR_EXC_CODE) ?
      20'h00100 :
    ({16'h0000, scratch_code} + 20'h00001);

  // ------------------------------------------------------------------
  // dispatch mask, one subspan per nibble
  // ------------------------------------------------------------------
  genvar g;
  generate
    for (g = 0; g < `PTPB_NSUB; g = g + 1) begin : g_dm
      // whole subspan on so derivatives see all four pixels
      assign dmask_w[4*g+3:4*g] = (|lit_mask[4*g+3:4*g]) ?
        `PTPB_ONES4 : `PTPB_ZERO4;
      // vertical in the high half, horizontal in the low half
      assign crd_word[32*(`PTPB_SSP_DW0+g)+31:32*(`PTPB_SSP_DW0+g)] =
        subspan_pos[32*g+31:32*g];
    end
  endgenerate

  // ------------------------------------------------------------------
  // coordinate register
  // ------------------------------------------------------------------
  // alpha to target implies alpha present
  assign alpha_eff = aa_alpha_present | aa_alpha_to_rt;
  // dword 7: viewport and array index; index meaning is up to the
  // surface kind, so it passes with no range check
  assign crd_dw7[`PTPB_VPRSV_BIT] = 1'b0;
  assign crd_dw7[`PTPB_VP_HI:`PTPB_VP_LO] = viewport_index;
  assign crd_dw7[`PTPB_RTA_HI:`PTPB_RTA_LO] = rt_array_index;
  assign crd_dw7[`PTPB_D7RSV_HI:`PTPB_D7RSV_LO] = 16'h0000;
  // dword 6: facing and presence flags
  assign crd_dw6[`PTPB_FACE_BIT] = back_facing;
  assign crd_dw6[`PTPB_SDP_BIT] = src_depth_present;
  assign crd_dw6[`PTPB_SDRT_BIT] = src_depth_to_rt;
  assign crd_dw6[`PTPB_DDP_BIT] = dst_depth_present;
  assign crd_dw6[`PTPB_DSP_BIT] = dst_stencil_present;
  assign crd_dw6[`PTPB_AART_BIT] = aa_alpha_to_rt;
  // a windower that forgets the present flag still gets alpha sent
  assign crd_dw6[`PTPB_AAP_BIT] = alpha_eff;
  assign crd_dw6[`PTPB_D6RSV_HI:`PTPB_D6RSV_LO] = 20'h00000;
  // topology passes as given, even for points
  assign crd_dw6[`PTPB_TOPO_HI:`PTPB_TOPO_LO] = topology_type;
  assign crd_word[255:192] = {crd_dw7, crd_dw6};
  assign crd_word[63:32] = start_vertical;
  assign crd_word[31:0] = start_horizontal;

  // ------------------------------------------------------------------
  // optional phases
  // ------------------------------------------------------------------
  // subspans 2 and 3 pass whatever the windower gives, even for 8-pixel
  assign dz0_word = src_depth[255:0];
  assign dz1_word = src_depth[511:256];
  assign as_needed = alpha_eff | dst_stencil_present;
  // dwords 4 and 5 of this beat are reserved
  assign as_word[191:128] = {2{`PTPB_ZERO32}};
  // each half meaningful only with its own flag; zeroing the other
  // half keeps stale windower data out of the thread
  generate
    for (g = 0; g < `PTPB_NSUB; g = g + 1) begin : g_as
      // alpha halfwords: subspans 0,1 in dword 6, subspans 2,3 in dword 7
      assign as_word[32*`PTPB_AA_DW_LO+16*g+15:32*`PTPB_AA_DW_LO+16*g] =
        alpha_eff ? aa_alpha[16*g+15:16*g] : 16'h0000;
      // stencil dword g holds subspan g, pixel 0 in the lowest byte
      assign as_word[32*g+31:32*g] = dst_stencil_present ?
        dst_stencil[32*g+31:32*g] : `PTPB_ZERO32;
    end
  endgenerate

  // ------------------------------------------------------------------
  // phase sequencing; skipped phases close up with no gap
  // ------------------------------------------------------------------
  // walk of one request:
  //   edge 0  request taken, header loaded
  //   edge 1  header shown; with ready, coordinates load
  //   edge 2  coordinates shown; depth or alpha/stencil load if wanted
  //   last    out_last marks the final beat; idle follows it
  // a stalled beat simply stays; nothing reloads without a phase change
  // trade-off: one idle cycle between requests keeps the control simple
  assign adv = out_valid & out_ready;
  assign req_ready = state_reg[0];
  assign req_busy = ~state_reg[0];

  always @* begin
    state_next = state_reg;
    case (state_reg)
      ST_IDLE: if (req_valid) state_next = ST_HDR;
      ST_HDR: if (adv) state_next = ST_CRD;
      ST_CRD: if (adv) begin
        state_next = src_depth_present ? ST_DZ0 :
          as_needed ? ST_AS : ST_IDLE;
      end
      ST_DZ0: if (adv) state_next = ST_DZ1;
      ST_DZ1: if (adv) state_next = as_needed ? ST_AS : ST_IDLE;
      ST_AS: if (adv) state_next = ST_IDLE;
      default: state_next = ST_IDLE;
    endcase
  end

  // word presented in the state being entered
  always @* begin
    word_sel = hdr_word;
    last_sel = 1'b0;
    case (state_next)
      ST_HDR: word_sel = hdr_word;
      ST_CRD: begin
        word_sel = crd_word;
        last_sel = ~src_depth_present & ~as_needed;
      end
      ST_DZ0: word_sel = dz0_word;
      ST_DZ1: begin
        word_sel = dz1_word;
        last_sel = ~as_needed;
      end
      ST_AS: begin
        word_sel = as_word;
        last_sel = 1'b1;
      end
      default: word_sel = hdr_word;
    endcase
  end

  // registered outputs; data only loads when the phase changes
  always @(posedge sys_clk) begin
    if (reset) begin
      state_reg <= ST_IDLE;
      out_valid <= 1'b0;
      out_data <= 256'h0;
      out_last <= 1'b0;
      dispatch_mask <= 16'h0000;
      scratch_bytes_kb <= 20'h00000;
    end else begin
      state_reg <= state_next;
      if (state_next != state_reg) begin
        out_valid <= ~state_next[0];
        out_data <= word_sel;
        out_last <= last_sel;
      end
      if (state_reg[0] && req_valid) begin
        dispatch_mask <= dmask_w;
        scratch_bytes_kb <= scr_kb_w;
      end
    end
  end

endmodule // ptpb_builder
`default_nettype wire

// file: test/ptpb_builder_sva.sv
// checker for the payload builder, bound onto the builder's ports
// assumes one clock and a synchronous active-high reset
`timescale 1ns/1ps
`default_nettype none
module ptpb_builder_sva (
  input wire logic sys_clk,
  input wire logic reset,
  input wire logic req_valid,
  input wire logic req_ready,
  input wire logic req_busy,
  input wire logic out_valid,
  input wire logic out_ready,
  input wire logic out_last,
  input wire logic [255:0] out_data,
  input wire logic [15:0] lit_mask,
  input wire logic [25:0] colour_calc_state_block,
  input wire logic [15:0] dispatch_mask
);
  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (reset);
  // whole-subspan activity derived from the lit mask
  wire [15:0] dm_w;
  wire take;
  assign dm_w = {{4{|lit_mask[15:12]}}, {4{|lit_mask[11:8]}},
    {4{|lit_mask[7:4]}}, {4{|lit_mask[3:0]}}};
  assign take = req_valid && req_ready;
  property p_hold;
    out_valid && !out_ready |=> out_valid && $stable(out_data);
  endproperty
  a_hold: assert property (p_hold) else $error("beat changed in stall");
  property p_refuse;
    take |=> req_busy && !req_ready;
  endproperty
  a_refuse: assert property (p_refuse) else $error("taken while busy");
  property p_hdr2;
    take |=> out_valid && out_data[95:64] == 32'h0;
  endproperty
  a_hdr2: assert property (p_hdr2) else $error("header dword 2");
  property p_hdr1;
    take |=> out_data[63:32] == {$past(colour_calc_state_block), 6'h0};
  endproperty
  a_hdr1: assert property (p_hdr1) else $error("header dword 1");
  property p_copy;
    take |=> out_data[31:16] == $past(lit_mask)
      && out_data[15:0] == $past(lit_mask);
  endproperty
  a_copy: assert property (p_copy) else $error("lit mask halves");
  property p_dmask;
    take |=> dispatch_mask == $past(dm_w);
  endproperty
  a_dmask: assert property (p_dmask) else $error("dispatch mask");
  property p_end;
    out_valid && out_ready && out_last |=> !out_valid && req_ready;
  endproperty
  a_end: assert property (p_end) else $error("beat after last");
  property p_busy;
    out_valid |-> req_busy;
  endproperty
  a_busy: assert property (p_busy) else $error("beat while idle");
endmodule // ptpb_builder_sva
bind ptpb_builder ptpb_builder_sva chk (.sys_clk(sys_clk), .reset(reset),
  .req_valid(req_valid), .req_ready(req_ready), .req_busy(req_busy),
  .out_valid(out_valid), .out_ready(out_ready), .out_last(out_last),
  .out_data(out_data), .lit_mask(lit_mask),
  .colour_calc_state_block(colour_calc_state_block),
  .dispatch_mask(dispatch_mask));
`default_nettype wire

// file: test/ptpb_shader_model.sv
// shader thread model: takes payload beats, stalling at random
// assumes beats hold while out_ready is low
`timescale 1ns/1ps
`default_nettype none
module ptpb_shader_model (
  input wire logic sys_clk,
  input wire logic out_valid,
  input wire logic [255:0] out_data,
  input wire logic out_last,
  output logic out_ready
);
  logic [255:0] got [0:1023];
  logic lst [0:1023];
  int n = 0;
  // stalls a third of cycles so the hold path is exercised
  initial out_ready = 1'b0;
  always @(negedge sys_clk) out_ready <= ($urandom % 3) != 0;
  // beats stored as received; the mask copy is never edited here
  always @(posedge sys_clk) begin
    if (out_valid && out_ready) begin
      got[n] <= out_data;
      lst[n] <= out_last;
      n <= n + 1;
    end
  end
endmodule // ptpb_shader_model
`default_nettype wire

// file: test/ptpb_builder_tb.sv
// self-checking bench for the payload builder with a shader model
// assumes the builder and the model files are compiled before it
`timescale 1ns/1ps
`default_nettype none
module ptpb_builder_tb;
  logic sys_clk = 0, reset = 1, req_valid = 0, out_ready, req_ready;
  logic out_valid, out_last, req_busy, early_stepping, scratch_exc_enable;
  logic back_facing, src_depth_present, src_depth_to_rt, dst_depth_present;
  logic dst_stencil_present, aa_alpha_to_rt, aa_alpha_present;
  logic [3:0] scratch_code, viewport_index;
  logic [4:0] topology_type;
  logic [10:0] rt_array_index;
  logic [15:0] lit_mask, dispatch_mask;
  logic [19:0] scratch_bytes_kb;
  logic [25:0] colour_calc_state_block;
  logic [31:0] start_vertical, start_horizontal;
  logic [63:0] aa_alpha;
  logic [127:0] subspan_pos;
  logic [127:0] dst_stencil;
  logic [255:0] out_data;
  logic [511:0] src_depth;
  logic [255:0] exp[$];
  int mismatches = 0, tests_run = 0;
  ptpb_builder dut (.*);
  ptpb_shader_model p (.sys_clk(sys_clk), .out_valid(out_valid),
    .out_data(out_data), .out_last(out_last), .out_ready(out_ready));
  initial forever #5 sys_clk = ~sys_clk;
  // ----------------------------------------
  // expectations
  // ----------------------------------------
  function automatic logic [19:0] kb(input logic [3:0] c);
    if (c > 4'hb) return 20'h0;
    if (!early_stepping) return 20'h1 << c;
    if (scratch_exc_enable && c == 4'hb) return 20'h100;
    return c + 20'h1;
  endfunction
  function automatic logic [15:0] dm(input logic [15:0] m);
    for (int s = 0; s < 4; s++) dm[4*s +: 4] = {4{|m[4*s +: 4]}};
  endfunction
  // reserved places stay zero, so each word starts cleared
  function automatic void build();
    logic [255:0] b;
    exp.delete();
    b = '0;
    b[99:0] = {scratch_code, 32'h0, colour_calc_state_block, 6'h0,
      lit_mask, lit_mask};
    exp.push_back(b);
    b = {1'b0, viewport_index, rt_array_index, 16'h0, back_facing,
      src_depth_present, src_depth_to_rt, dst_depth_present,
      dst_stencil_present, aa_alpha_to_rt,
      aa_alpha_present | aa_alpha_to_rt, 20'h0,
      topology_type, 128'h0, start_vertical, start_horizontal};
    for (int g = 0; g < 4; g++) b[64+32*g +: 32] = subspan_pos[32*g +: 32];
    exp.push_back(b);
    if (src_depth_present) exp.push_back(src_depth[255:0]);
    if (src_depth_present) exp.push_back(src_depth[511:256]);
    b = '0;
    if (dst_stencil_present) b[127:0] = dst_stencil;
    if (aa_alpha_present || aa_alpha_to_rt) b[255:192] = aa_alpha;
    if (aa_alpha_present || aa_alpha_to_rt || dst_stencil_present)
      exp.push_back(b);
  endfunction
  task automatic chk(input logic ok, input string m);
    tests_run++;
    if (ok !== 1'b1) begin
      mismatches++;
      $display("CHECK FAILED %0t %s", $time, m);
    end
  endtask
  // k: 0 random, 1 every presence flag on but alpha to target random, 2 no options, 3 alpha to target on, alpha present off, rest random
  task automatic rnd(input int k);
    {scratch_code, early_stepping, scratch_exc_enable} = $urandom;
    {viewport_index, rt_array_index, back_facing, topology_type} = $urandom;
    {src_depth_present, src_depth_to_rt, dst_depth_present,
      dst_stencil_present, aa_alpha_present} = k == 1 ? 5'h1f :
      k == 2 ? 5'h0 : 5'($urandom);
    aa_alpha_to_rt = k == 3 ? 1'b1 : aa_alpha_present & $urandom;
    if (k == 3) aa_alpha_present = 1'b0;
    colour_calc_state_block = $urandom;
    lit_mask = k == 2 ? 16'h0 : $urandom;
    {start_vertical, start_horizontal} = {$urandom, $urandom};
    {subspan_pos, aa_alpha} = {$urandom, $urandom, $urandom, $urandom,
      $urandom, $urandom};
    for (int i = 0; i < 16; i++) src_depth[32*i +: 32] = $urandom;
    for (int i = 0; i < 4; i++) dst_stencil[32*i +: 32] = $urandom;
  endtask
  task automatic send(input int k);
    int b0, t;
    rnd(k);
    build();
    for (t = 0; t < 50 && req_ready !== 1'b1; t++) @(negedge sys_clk);
    b0 = p.n;
    req_valid = 1'b1;
    @(negedge sys_clk);
    req_valid = 1'b0;
    chk(dispatch_mask === dm(lit_mask), "dispatch mask");
    chk(scratch_bytes_kb === kb(scratch_code), "scratch size");
    for (t = 0; t < 200 && req_busy !== 1'b0; t++) @(negedge sys_clk);
    chk(p.n - b0 == exp.size(), "beat count");
    for (int i = 0; i < exp.size(); i++) begin
      chk(p.got[b0+i] === exp[i], "payload word");
      chk(p.lst[b0+i] === (i == exp.size() - 1), "last flag");
    end
  endtask
  task automatic summarize();
    if (mismatches == 0 && tests_run > 0) $display("Finished cleanly");
    else $display("Finished with errors");
    $finish;
  endtask
  initial begin
    void'($urandom(90));
    rnd(2);
    repeat (3) @(negedge sys_clk);
    reset = 1'b0;
    send(1);
    send(2);
    send(3);
    for (int i = 0; i < 60; i++) send(0);
    summarize();
  end
  // watchdog well past the expected run length
  initial begin
    #100000;
    mismatches++;
    summarize();
  end
endmodule // ptpb_builder_tb
`default_nettype wire
